// [core/ccs_sequencer.sv]
// Conversion sequencer: start relay along the chain, channel stepping and averaging.
`timescale 1ns/100ps
// Contract
// - One start at the master makes every part of up to 50 convert.
// - Start comes from a low start pulse or a rising chip-select edge.
// - Each part relays its received start to the part above, except a start in local self-test.
// - Master-to-top skew is at most hop delay times part count.
// - Chain time is (acq+conv) times 6/9/12, plus hops.
// - Self-test routes the internal bandgap reference to the converter.
// - Self-test may run on one part alone or chain-wide.
// - Self-test results use the same compare path as normal results.
// - Two-bit averaging field selects 1, 2, 4 or 8 conversions.
// - Averaging resets to a single conversion per channel.
// - Averaged result lands in the channel's own result slot.
// - Every sequence except self-test converts all six voltage channels.
// - All six voltage results are offered; host drops unused ones.
// - Two-bit field selects six, odd three or no temperature inputs.
// - Separate two-bit field sets the readback result count.
// - Two alert bits exclude temperature inputs five and three.
// - A control bit enables the shared thermistor termination input.
// - Shortest acquisition time is the reset default.
// - Acquisition field gives 400, 800, 1200 or 1600 ns of tracking.
// - Select field: all, voltages plus odd temps, voltages, self-test.
// - Each result write, after the last averaged conversion, steps the mux; cell one is reselected after.
module ccs_sequencer #(
	parameter int HOP_CYCLES = ccs_pkg::HOP_CYC
) (
	input  wire  logic                        mclk,
	input  wire  logic                        rst_b,
	input  wire  logic                        conversion_start_n,
	input  wire  logic                        cs_n,
	input  wire  logic                        chain_start_in,
	input  wire  logic                        chain_master,
	input  wire  logic                        self_test_local,
	input  wire  logic                        ctrl_wr,
	input  wire  logic [ccs_pkg::CTRL_W-1:0]  ctrl_wdata,
	input  wire  logic                        alert_wr,
	input  wire  logic [ccs_pkg::ALERT_W-1:0] alert_wdata,
	input  wire  logic                        adc_done,
	input  wire  logic [ccs_pkg::ADC_W-1:0]   adc_data,
	output logic [ccs_pkg::CTRL_W-1:0]        ctrl_rdata,
	output logic [ccs_pkg::ALERT_W-1:0]       alert_rdata,
	output logic [1:0]                        readback_count,
	output logic                              thermistor_termination_en,
	output logic                              chain_start_out,
	output logic [ccs_pkg::CH_W-1:0]          mux_sel,
	output logic                              track,
	output logic                              adc_start,
	output logic                              busy,
	output logic                              res_we,
	output logic [ccs_pkg::CH_W-1:0]          res_addr,
	output logic [ccs_pkg::ADC_W-1:0]         res_data,
	output logic                              res_alert_en
);

	// ----------------------------------------------------------------
	// Pin synchronisers and start detection
	// ----------------------------------------------------------------
	logic [3:0]            sync1;
	logic [3:0]            sync2;
	logic [3:0]            sync3;
	logic [HOP_CYCLES-1:0] hop;
	logic [HOP_CYCLES-1:0] next_hop;
	logic                  start_evt;
	logic                  relay_evt;
	// Bit order: start pulse, chip select, chain input, master strap.
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sync1 <= 4'hf;
			sync2 <= 4'hf;
			sync3 <= 4'hf;
			hop   <= '0;
		end
		else
		begin
			sync1 <= {chain_master, chain_start_in, cs_n, conversion_start_n};
			sync2 <= sync1;
			sync3 <= sync2;
			hop   <= next_hop;
		end
	end
	always_comb
	begin
		if (sync2[3])
			start_evt = (!sync2[0] && sync3[0]) || (sync2[1] && !sync3[1]);
		else
			start_evt = sync2[2] && !sync3[2];
		relay_evt = start_evt && !(self_test_local &&
			ctrl_rdata[ccs_pkg::SEL_HI:ccs_pkg::SEL_LO] == ccs_pkg::SEL_TEST);
		next_hop = {hop[HOP_CYCLES-2:0], relay_evt};
	end
	assign chain_start_out = hop[HOP_CYCLES-1];
	// ----------------------------------------------------------------
	// Control and alert configuration registers
	// ----------------------------------------------------------------
	logic [ccs_pkg::CTRL_W-1:0]  next_ctrl;
	logic [ccs_pkg::ALERT_W-1:0] next_alert;
	always_comb
	begin
		next_ctrl  = ctrl_wr ? ctrl_wdata : ctrl_rdata;
		next_alert = alert_wr ? alert_wdata : alert_rdata;
	end
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ctrl_rdata  <= ccs_pkg::CTRL_RST;
			alert_rdata <= ccs_pkg::ALERT_RST;
		end
		else
		begin
			ctrl_rdata  <= next_ctrl;
			alert_rdata <= next_alert;
		end
	end
	assign readback_count            = ctrl_rdata[ccs_pkg::RDBK_HI:ccs_pkg::RDBK_LO];
	assign thermistor_termination_en = ctrl_rdata[ccs_pkg::TERM_BIT];

	// ----------------------------------------------------------------
	// Channel stepping
	// ----------------------------------------------------------------
	// Returns {last, next channel} for the given mode and current channel.
	function automatic logic [ccs_pkg::CH_W:0] step_chan(input logic [1:0] mode,
		input logic [ccs_pkg::CH_W-1:0] ch);
		logic last;
		logic [ccs_pkg::CH_W-1:0] nxt;
		last = 1'b0;
		nxt  = ch + ccs_pkg::CH_STEP;
		unique case (mode)
			ccs_pkg::SEL_ALL:  last = (ch == ccs_pkg::CH_T6);
			ccs_pkg::SEL_ODD:
			begin
				last = (ch == ccs_pkg::CH_T5);
				if (ch >= ccs_pkg::CH_T1)
					nxt = ch + ccs_pkg::CH_STEP2;
			end
			ccs_pkg::SEL_VOLT: last = (ch == ccs_pkg::CH_V6);
			ccs_pkg::SEL_TEST: last = 1'b1;
		endcase
		return {last, nxt};
	endfunction : step_chan

	// ----------------------------------------------------------------
	// Sequencer state machine
	// ----------------------------------------------------------------
	localparam int SUM_W = ccs_pkg::ADC_W + ccs_pkg::AVG_MAX_SH;
	ccs_pkg::ccs_state_t        state;
	ccs_pkg::ccs_state_t        next_state;
	logic [1:0]                 cur_mode;
	logic [1:0]                 next_cur_mode;
	logic [1:0]                 cur_avg;
	logic [1:0]                 next_cur_avg;
	logic [4:0]                 acq_target;
	logic [4:0]                 next_acq_target;
	logic [4:0]                 acq_cnt;
	logic [4:0]                 next_acq_cnt;
	logic [2:0]                 rep;
	logic [2:0]                 next_rep;
	logic [SUM_W-1:0]           sum;
	logic [SUM_W-1:0]           next_sum;
	logic [SUM_W-1:0]           sum_in;
	logic [ccs_pkg::CH_W:0]     stepped;
	logic [ccs_pkg::CH_W-1:0]   next_mux_sel;
	logic                       next_adc_start;
	logic                       next_res_we;
	logic [ccs_pkg::CH_W-1:0]   next_res_addr;
	logic [ccs_pkg::ADC_W-1:0]  next_res_data;
	logic                       next_res_alert_en;
	always_comb
	begin
		next_state        = state;
		next_cur_mode     = cur_mode;
		next_cur_avg      = cur_avg;
		next_acq_target   = acq_target;
		next_acq_cnt      = acq_cnt;
		next_rep          = rep;
		next_sum          = sum;
		next_mux_sel      = mux_sel;
		next_adc_start    = 1'b0;
		next_res_we       = 1'b0;
		next_res_addr     = res_addr;
		next_res_data     = res_data;
		next_res_alert_en = res_alert_en;
		sum_in            = sum + SUM_W'(adc_data);
		stepped           = step_chan(cur_mode, mux_sel);
		unique case (state)
			ccs_pkg::ST_IDLE:
			begin
				next_mux_sel = ccs_pkg::CH_V1;
				if (start_evt)
				begin
					next_state      = ccs_pkg::ST_ACQ;
					next_cur_mode   = ctrl_rdata[ccs_pkg::SEL_HI:ccs_pkg::SEL_LO];
					next_cur_avg    = ctrl_rdata[ccs_pkg::AVG_HI:ccs_pkg::AVG_LO];
					next_acq_target = 5'((32'(ctrl_rdata[ccs_pkg::ACQ_HI:ccs_pkg::ACQ_LO]) + 1)
						* ccs_pkg::ACQ_STEP_CYC);
					next_acq_cnt    = '0;
					next_rep        = '0;
					next_sum        = '0;
					if (ctrl_rdata[ccs_pkg::SEL_HI:ccs_pkg::SEL_LO] == ccs_pkg::SEL_TEST)
						next_mux_sel = ccs_pkg::CH_BG;
				end
			end
			ccs_pkg::ST_ACQ:
			begin
				next_acq_cnt = acq_cnt + 5'h01;
				if (acq_cnt == acq_target - 5'h01)
				begin
					next_adc_start = 1'b1;
					next_state     = ccs_pkg::ST_CONV;
					next_acq_cnt   = '0;
				end
			end
			ccs_pkg::ST_CONV:
			begin
				if (adc_done)
				begin
					next_state = ccs_pkg::ST_ACQ;
					next_sum   = sum_in;
					next_rep   = rep + 3'h1;
					if (rep == 3'((32'h1 << cur_avg) - 1))
					begin
						next_res_we       = 1'b1;
						next_res_addr     = mux_sel;
						next_res_data     = ccs_pkg::ADC_W'(sum_in >> cur_avg);
						next_res_alert_en = !((mux_sel == ccs_pkg::CH_T5 &&
							alert_rdata[ccs_pkg::EXCL_T5]) || (mux_sel == ccs_pkg::CH_T3 &&
							alert_rdata[ccs_pkg::EXCL_T3]));
						next_rep          = '0;
						next_sum          = '0;
						if (stepped[ccs_pkg::CH_W])
						begin
							next_state   = ccs_pkg::ST_IDLE;
							next_mux_sel = ccs_pkg::CH_V1;
						end
						else
							next_mux_sel = stepped[ccs_pkg::CH_W-1:0];
					end
				end
			end
		endcase
	end
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state        <= ccs_pkg::ST_IDLE;
			cur_mode     <= ccs_pkg::SEL_ALL;
			cur_avg      <= '0;
			acq_target   <= 5'h01;
			acq_cnt      <= '0;
			rep          <= '0;
			sum          <= '0;
			mux_sel      <= ccs_pkg::CH_V1;
			adc_start    <= 1'b0;
			res_we       <= 1'b0;
			res_addr     <= ccs_pkg::CH_V1;
			res_data     <= '0;
			res_alert_en <= 1'b0;
		end
		else
		begin
			state        <= next_state;
			cur_mode     <= next_cur_mode;
			cur_avg      <= next_cur_avg;
			acq_target   <= next_acq_target;
			acq_cnt      <= next_acq_cnt;
			rep          <= next_rep;
			sum          <= next_sum;
			mux_sel      <= next_mux_sel;
			adc_start    <= next_adc_start;
			res_we       <= next_res_we;
			res_addr     <= next_res_addr;
			res_data     <= next_res_data;
			res_alert_en <= next_res_alert_en;
		end
	end
	assign track = (state == ccs_pkg::ST_ACQ);
	assign busy  = (state != ccs_pkg::ST_IDLE);
	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	logic [7:0] since_relay;
	logic [4:0] acq_len;
	logic [3:0] done_cnt;
	logic [2:0] volt_cnt;
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			since_relay <= 8'hff;
			acq_len     <= '0;
			done_cnt    <= '0;
			volt_cnt    <= '0;
		end
		else
		begin
			since_relay <= relay_evt ? 8'h00 : (since_relay == 8'hff ? since_relay : since_relay + 8'h01);
			acq_len     <= track ? acq_len + 5'h01 : 5'h00;
			done_cnt    <= res_we ? 4'(adc_done && busy) : done_cnt + 4'(adc_done && busy);
			volt_cnt    <= !busy ? 3'h0 : volt_cnt + 3'(res_we && res_addr <= ccs_pkg::CH_V6);
		end
	end
	sequence start_idle_s;
		start_evt && state == ccs_pkg::ST_IDLE;
	endsequence
	sequence acq_begun_s;
		track && busy ##1 track;
	endsequence
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	start_accept_a: assert property (start_idle_s |=> acq_begun_s)
		else $error("start in idle did not begin acquisition");
	relay_hop_a: assert property (chain_start_out |-> since_relay == 8'(HOP_CYCLES - 1))
		else $error("relayed start not at the fixed hop latency");
	acq_len_a: assert property (adc_start |-> acq_len == acq_target)
		else $error("acquisition length does not match setting");
	self_test_mux_a: assert property (busy && cur_mode == ccs_pkg::SEL_TEST
		|-> mux_sel == ccs_pkg::CH_BG)
		else $error("self-test did not select the bandgap");
	avg_count_a: assert property (res_we |-> done_cnt == 4'(1 << cur_avg))
		else $error("result written after wrong number of conversions");
	odd_temps_a: assert property (res_we && cur_mode == ccs_pkg::SEL_ODD
		&& res_addr >= ccs_pkg::CH_T1 |-> !res_addr[0])
		else $error("even temperature input converted in odd mode");
	mux_home_a: assert property ($fell(busy) |-> mux_sel == ccs_pkg::CH_V1 ##1 !adc_start)
		else $error("cell one not reselected after the sequence");
	all_volts_a: assert property ($fell(busy) && cur_mode != ccs_pkg::SEL_TEST
		|-> volt_cnt + 3'(res_we && res_addr <= ccs_pkg::CH_V6) == 3'(ccs_pkg::VOLT_CHANS))
		else $error("not every voltage channel was converted");
	alert_excl_a: assert property (res_we && res_addr == ccs_pkg::CH_T5
		&& alert_rdata[ccs_pkg::EXCL_T5] |-> !res_alert_en)
		else $error("excluded input five reached the alert path");
endmodule : ccs_sequencer

// [core/ccs_pkg.sv]
// Constants, field positions and types of the chain conversion sequencer.
package ccs_pkg;

	// ----------------------------------------------------------------
	// Conversion control register layout
	// ----------------------------------------------------------------
	localparam int          CTRL_W     = 16;
	localparam logic [15:0] CTRL_RST   = 16'h0000;
	localparam int          SEL_HI     = 15;
	localparam int          SEL_LO     = 14;
	localparam int          RDBK_HI    = 13;
	localparam int          RDBK_LO    = 12;
	localparam int          AVG_HI     = 10;
	localparam int          AVG_LO     = 9;
	localparam int          ACQ_HI     = 6;
	localparam int          ACQ_LO     = 5;
	localparam int          TERM_BIT   = 3;

	// ----------------------------------------------------------------
	// Alert configuration register layout
	// ----------------------------------------------------------------
	localparam int          ALERT_W    = 8;
	localparam logic [7:0]  ALERT_RST  = 8'h00;
	localparam int          EXCL_T5    = 1;
	localparam int          EXCL_T3    = 0;

	// ----------------------------------------------------------------
	// Channel selection modes and multiplexer codes
	// ----------------------------------------------------------------
	localparam logic [1:0]  SEL_ALL    = 2'h0;
	localparam logic [1:0]  SEL_ODD    = 2'h1;
	localparam logic [1:0]  SEL_VOLT   = 2'h2;
	localparam logic [1:0]  SEL_TEST   = 2'h3;
	localparam int          CH_W       = 4;
	localparam logic [3:0]  CH_V1      = 4'h0;
	localparam logic [3:0]  CH_V6      = 4'h5;
	localparam logic [3:0]  CH_T1      = 4'h6;
	localparam logic [3:0]  CH_T3      = 4'h8;
	localparam logic [3:0]  CH_T5      = 4'ha;
	localparam logic [3:0]  CH_T6      = 4'hb;
	localparam logic [3:0]  CH_BG      = 4'hc;
	localparam logic [3:0]  CH_STEP    = 4'h1;
	localparam logic [3:0]  CH_STEP2   = 4'h2;
	localparam int          VOLT_CHANS = 6;
	localparam int          MAX_PARTS  = 50;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int          CLK_NS     = 100;
	localparam int          ACQ_STEP_NS = 400;
	localparam int          ACQ_STEP_CYC = (ACQ_STEP_NS + CLK_NS - 1) / CLK_NS;
	localparam int          HOP_NS     = 400;
	localparam int          HOP_CYC    = (HOP_NS + CLK_NS - 1) / CLK_NS;
	localparam int          ADC_W      = 12;
	localparam int          AVG_MAX_SH = 3;

	typedef enum logic [1:0] {ST_IDLE, ST_ACQ, ST_CONV} ccs_state_t;

endpackage : ccs_pkg

// [test/ccs_adc_model.sv]
// Behavioural converter that answers every conversion start with a channel-coded result.
`timescale 1ns/100ps
module ccs_adc_model #(
	parameter int CONV_CYC = 6
) (
	input  wire  logic        mclk,
	input  wire  logic        rst_b,
	input  wire  logic        adc_start,
	input  wire  logic        busy,
	input  wire  logic [3:0]  mux_sel,
	output logic              adc_done,
	output logic [11:0]       adc_data
);
	int          cnt;
	logic [3:0]  rep;
	logic [3:0]  last;
	logic [3:0]  r;
	logic [11:0] val;

	// The data lines show the inverse outside the done cycle, so a late capture is caught.
	assign adc_data = adc_done ? val : ~val;

	// Each repeat on one channel adds one to the result, so averaging shows in the data.
	always @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cnt      <= 0;
			rep      <= 4'h0;
			last     <= 4'hf;
			val      <= 12'h000;
			adc_done <= 1'b0;
		end
		else
		begin
			adc_done <= 1'b0;
			if (adc_start)
				cnt <= CONV_CYC;
			else if (cnt > 0)
			begin
				cnt <= cnt - 1;
				if (cnt == 1)
				begin
					r = (mux_sel == last) ? rep : 4'h0;
					val      <= {mux_sel, 8'h10} + 12'(r);
					rep      <= r + 4'h1;
					last     <= mux_sel;
					adc_done <= 1'b1;
				end
			end
			if (!busy)
				last <= 4'hf;
		end
	end
endmodule : ccs_adc_model

// [test/ccs_sequencer_tb_top.sv]
// Self-checking testbench of the chain conversion sequencer.
`timescale 1ns/100ps
module ccs_sequencer_tb_top;
	localparam int HOP     = 4;
	localparam int NCH[4]  = '{12, 9, 6, 1};
	localparam int OFF[4]  = '{0, 0, 1, 3};
	logic        mclk, rst_b, conversion_start_n, cs_n, chain_start_in, chain_master;
	logic        self_test_local, ctrl_wr, alert_wr, adc_done, term_en, chain_start_out;
	logic        track, adc_start, busy, res_we, res_alert_en;
	logic [15:0] ctrl_wdata, ctrl_rdata;
	logic [7:0]  alert_wdata, alert_rdata;
	logic [11:0] adc_data, res_data;
	logic [3:0]  mux_sel, res_addr;
	logic [1:0]  readback_count;
	logic [3:0]  q_a[$];
	logic [11:0] q_d[$];
	logic        q_e[$];
	logic        busy_d;
	int          num_errors, n_compared, cyc, t_busy, t_relay, n_relay, tr_run, tr_len;

	ccs_sequencer #(.HOP_CYCLES(HOP)) ccs_sequencer_i (.mclk(mclk), .rst_b(rst_b),
		.conversion_start_n(conversion_start_n), .cs_n(cs_n), .chain_start_in(chain_start_in),
		.chain_master(chain_master), .self_test_local(self_test_local), .ctrl_wr(ctrl_wr),
		.ctrl_wdata(ctrl_wdata), .alert_wr(alert_wr), .alert_wdata(alert_wdata),
		.adc_done(adc_done), .adc_data(adc_data), .ctrl_rdata(ctrl_rdata),
		.alert_rdata(alert_rdata), .readback_count(readback_count),
		.thermistor_termination_en(term_en), .chain_start_out(chain_start_out),
		.mux_sel(mux_sel), .track(track), .adc_start(adc_start), .busy(busy),
		.res_we(res_we), .res_addr(res_addr), .res_data(res_data),
		.res_alert_en(res_alert_en));
	ccs_adc_model ccs_adc_model_i (.mclk(mclk), .rst_b(rst_b), .adc_start(adc_start),
		.busy(busy), .mux_sel(mux_sel), .adc_done(adc_done), .adc_data(adc_data));

	// ----------------------------------------------------------------
	// Clock, watchdog and port monitor
	// ----------------------------------------------------------------
	initial
	begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	initial
	begin
		#2000000;
		num_errors++;
		end_of_test();
	end
	// Outputs are sampled at the falling edge, where they have settled.
	always @(negedge mclk)
	begin
		cyc++;
		if (res_we === 1'b1)
		begin
			q_a.push_back(res_addr);
			q_d.push_back(res_data);
			q_e.push_back(res_alert_en);
		end
		if (busy === 1'b1 && busy_d !== 1'b1)
			t_busy = cyc;
		if (chain_start_out === 1'b1)
		begin
			t_relay = cyc;
			n_relay++;
		end
		if (track === 1'b1)
			tr_run++;
		else if (tr_run != 0)
		begin
			tr_len = tr_run;
			tr_run = 0;
		end
		busy_d = busy;
	end

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
		n_compared++;
		if (g !== e)
		begin
			num_errors++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic chk_n(string nm, int e, int g);
		n_compared++;
		if (g != e)
		begin
			num_errors++;
			$display("FAIL %s expected %0d seen %0d", nm, e, g);
		end
	endtask : chk_n
	task automatic end_of_test;
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_of_test
	task automatic wreg(bit alr, logic [15:0] d);
		@(negedge mclk);
		if (alr)
		begin
			alert_wdata = d[7:0];
			alert_wr = 1'b1;
		end
		else
		begin
			ctrl_wdata = d;
			ctrl_wr = 1'b1;
		end
		@(negedge mclk);
		ctrl_wr = 1'b0;
		alert_wr = 1'b0;
		@(negedge mclk);
	endtask : wreg
	// Kind 0 pulses the start pin, 1 raises chip select, 2 is a start from below.
	task automatic start(int k);
		@(negedge mclk);
		if (k == 0) conversion_start_n = 1'b0;
		if (k == 1) cs_n = 1'b0;
		if (k == 2) chain_start_in = 1'b1;
		repeat (3) @(negedge mclk);
		conversion_start_n = 1'b1;
		cs_n = 1'b1;
		chain_start_in = 1'b0;
	endtask : start
	task automatic run(logic [15:0] c, int k, int k2 = -1);
		int i;
		wreg(0, c);
		q_a.delete();
		q_d.delete();
		q_e.delete();
		n_relay = 0;
		start(k);
		i = 0;
		while (busy !== 1'b1 && i < 50) begin @(negedge mclk); i++; end
		if (k2 >= 0) start(k2);
		while (busy !== 1'b0 && i < 5000) begin @(negedge mclk); i++; end
		chk_n("sequence finished", 1, (i < 5000) ? 1 : 0);
		repeat (HOP + 2) @(negedge mclk);
	endtask : run
	function automatic logic [3:0] exp_ch(logic [1:0] m, int i);
		if (m == 2'h3) return 4'hc;
		if (m == 2'h1 && i > 5) return 4'(6 + 2 * (i - 6));
		return 4'(i);
	endfunction : exp_ch
	task automatic chk_seq(logic [1:0] m, int off);
		chk_n("result count", NCH[m], q_a.size());
		foreach (q_a[j])
		begin
			chk("result channel", 16'(exp_ch(m, j)), 16'(q_a[j]));
			chk("result data", 16'({exp_ch(m, j), 8'h10} + off), 16'(q_d[j]));
		end
		chk("mux after sequence", 16'h0, 16'(mux_sel));
	endtask : chk_seq

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset;
		chk("control reset", 16'h0000, ctrl_rdata);
		chk("alert reset", 16'h0000, 16'(alert_rdata));
		chk("termination reset", 16'h0, 16'(term_en));
		$display("test reset done");
	endtask : t_reset
	task automatic t_regs;
		wreg(0, 16'h5068);
		chk("control readback", 16'h5068, ctrl_rdata);
		chk("readback count", 16'h1, 16'(readback_count));
		chk("termination enable", 16'h1, 16'(term_en));
		wreg(0, 16'h2000);
		chk("readback independent", 16'h2, 16'(readback_count));
		wreg(1, 16'h0003);
		chk("alert readback", 16'h0003, 16'(alert_rdata));
		wreg(1, 16'h0000);
		$display("test registers done");
	endtask : t_regs
	task automatic t_modes;
		for (int m = 0; m < 4; m++)
		begin
			run({m[1:0], 14'h0}, m % 2);
			chk_seq(m[1:0], 0);
			chk_n("relay count", 1, n_relay);
			chk_n("relay delay", HOP - 1, t_relay - t_busy);
			chk_n("track cycles", 4, tr_len);
			foreach (q_e[j]) chk("alert enable", 16'h1, 16'(q_e[j]));
		end
		$display("test modes done");
	endtask : t_modes
	task automatic t_avg_acq;
		for (int a = 1; a < 4; a++)
		begin
			run(16'h8000 | 16'(a << 9), 0);
			chk_seq(2'h2, OFF[a]);
			run(16'h8000 | 16'(a << 5), 1);
			chk_n("track cycles", 4 * (a + 1), tr_len);
		end
		$display("test averaging and acquisition done");
	endtask : t_avg_acq
	task automatic t_alert;
		wreg(1, 16'h0003);
		run(16'h4000, 0);
		foreach (q_e[j])
			chk("alert exclusion", 16'(!(q_a[j] == 4'h8 || q_a[j] == 4'ha)), 16'(q_e[j]));
		wreg(1, 16'h0000);
		$display("test alert exclusion done");
	endtask : t_alert
	task automatic t_chain;
		chain_master = 1'b0;
		repeat (4) @(negedge mclk);
		run(16'h8000, 2);
		chk_seq(2'h2, 0);
		chk_n("relay from below", 1, n_relay);
		chain_master = 1'b1;
		repeat (4) @(negedge mclk);
		self_test_local = 1'b1;
		run(16'hc000, 0);
		chk_seq(2'h3, 0);
		chk_n("local test relay", 0, n_relay);
		self_test_local = 1'b0;
		run(16'h8000, 0, 1);
		chk_seq(2'h2, 0);
		chk_n("busy start relayed", 2, n_relay);
		$display("test chain done");
	endtask : t_chain

	initial
	begin
		{conversion_start_n, cs_n, chain_master, rst_b} = 4'b1110;
		{chain_start_in, self_test_local, ctrl_wr, alert_wr} = 4'b0000;
		ctrl_wdata = 16'h0000;
		alert_wdata = 8'h00;
		repeat (3) @(negedge mclk);
		rst_b = 1'b1;
		repeat (3) @(negedge mclk);
		t_reset();
		t_regs();
		t_modes();
		t_avg_acq();
		t_alert();
		t_chain();
		end_of_test();
	end
endmodule : ccs_sequencer_tb_top
